/* inc/ccb_pkg.sv */
// Package for the processor-side cache-control bus pin logic.
// Assumes one bus clock; bus pins active low, the copy-back strap active high, all sampled on rising edges.
package ccb_pkg;

   // ****************************************************************
   // Reset values and synchroniser depth
   // ****************************************************************
   localparam logic       PIN_IDLE      = 1'b1;
   localparam logic       MODE_COPYBACK = 1'b1;
   localparam int unsigned SYNC_DEPTH   = 3;
   localparam logic [1:0] XFER_ONE      = 2'h1;

   // ****************************************************************
   // Bundles
   // ****************************************************************
   typedef struct packed {
      logic       start;       // one-cycle request from the core
      logic       write;
      logic       want_fill;   // core would like to fill a line
      logic [1:0] xfers;       // transfers needed if not cached
   } ccb_req_t;

   typedef struct packed {
      logic hit_clean;  // snoop hit a clean line (pulse)
      logic hit_dirty;  // snoop hit a modified line (pulse)
      logic wb_done;    // core reports writeback finished (pulse)
   } ccb_snoop_t;

endpackage

/* design/ccb_sync.sv */
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes the pin is asynchronous to core_clk.
`timescale 1ns/1ps
module ccb_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic resetn,
   // Pin and result
   input  wire logic pin_in,
   output logic      level_out
);

   logic [ccb_pkg::SYNC_DEPTH-1:0] stage_reg;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         stage_reg <= {ccb_pkg::SYNC_DEPTH{RESET_VAL}};
      end else begin
         stage_reg <= {stage_reg[ccb_pkg::SYNC_DEPTH-2:0], pin_in};
      end
   end

   // The first stage feeds only the second; a change counts once stages two and three agree.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         level_out <= RESET_VAL;
      end else if (stage_reg[1] == stage_reg[2]) begin
         level_out <= stage_reg[2];
      end
   end

endmodule

/* design/ccb_pins.sv */
// Cache-control bus pins: linefill intent, cacheability, final transfer, snoop results.
// Assumes the core issues bus requests as pulses and the chipset drives the pins.
`timescale 1ns/1ps
// How it works
// - On a read the linefill-intent output goes low when the core wants a whole line.
// - Linefill intent alone never forces the final-transfer output high.
// - A one-transfer access that sees the grant high drives final-transfer low.
// - The copy-back strap is held by the chipset and latched at reset rising.
// - Linefill intent is driven in either mode; both snoop outputs report hits only in copy-back mode.
// - In write-through mode both snoop outputs stay high.
// - In write-through mode linefill intent goes low on fill reads only and stays high on writes.
// - A snoop hit on a dirty line drives the dirty-match output low until the writeback.
// - Dirty match is released after the last burst-done, at the latest on the edge that drives the next address strobe low.
module ccb_pins (
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               resetn,
   // Mode strap
   input  wire logic               copyback_select,
   // Core side
   input  wire ccb_pkg::ccb_req_t  req,
   input  wire ccb_pkg::ccb_snoop_t snoop,
   output logic                    busy,
   output logic                    copyback_mode,
   output logic                    granted,
   // Bus pins
   input  wire logic               cacheability_grant_n,
   input  wire logic               burst_done_n,
   output logic                    address_strobe_n,
   output logic                    linefill_intent_n,
   output logic                    final_transfer_n,
   output logic                    snoop_clean_match_n,
   output logic                    snoop_dirty_match_n
);

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   logic grant_n_s;
   logic bdone_n_s;
   logic strap_s;

   ccb_sync #(.RESET_VAL(1'b1)) u_grant (
      .core_clk  (core_clk),
      .resetn    (resetn),
      .pin_in    (cacheability_grant_n),
      .level_out (grant_n_s)
   );

   ccb_sync #(.RESET_VAL(1'b1)) u_bdone (
      .core_clk  (core_clk),
      .resetn    (resetn),
      .pin_in    (burst_done_n),
      .level_out (bdone_n_s)
   );

   // The strap chain is never reset. It has to carry the pin level while reset is low.
   // A reset chain would hold its reset value and always pick copy-back mode.
   // Its flops start unknown, so reset must last a few clocks for the chain to settle.
   ccb_sync #(.RESET_VAL(ccb_pkg::MODE_COPYBACK)) u_strap (
      .core_clk  (core_clk),
      .resetn    (1'b1),
      .pin_in    (copyback_select),
      .level_out (strap_s)
   );

   // ****************************************************************
   // Mode strap capture
   // ****************************************************************
   // The asynchronous reset cannot load a pin, so the strap is caught each clock
   // while reset is low and frozen at the first edge after release.
   logic rst_seen_reg;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rst_seen_reg <= 1'b0;
      end else begin
         rst_seen_reg <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_seen_reg) begin
         copyback_mode <= strap_s;
      end
   end

   // ****************************************************************
   // Bus cycle sequencer
   // ****************************************************************
   typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} ccb_state_t;

   ccb_state_t state_reg;
   logic       write_reg;
   logic       fill_reg;
   logic [1:0] left_reg;
   logic       last_beat;

   // Burst-done low in the data phase ends one transfer.
   assign last_beat = (state_reg == ST_DATA) && !bdone_n_s && (left_reg == ccb_pkg::XFER_ONE);

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= ST_IDLE;
         write_reg <= 1'b0;
         fill_reg  <= 1'b0;
         left_reg  <= ccb_pkg::XFER_ONE;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (req.start) begin
                  state_reg <= ST_ADDR;
                  write_reg <= req.write;
                  fill_reg  <= req.want_fill && !req.write;
                  left_reg  <= (req.xfers == 2'h0) ? ccb_pkg::XFER_ONE : req.xfers;
               end
            end
            ST_ADDR: begin
               state_reg <= ST_DATA;
            end
            ST_DATA: begin
               if (!bdone_n_s) begin
                  if (left_reg == ccb_pkg::XFER_ONE) begin
                     state_reg <= ST_IDLE;
                  end else begin
                     left_reg <= left_reg - 2'h1;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         busy <= 1'b0;
      end else begin
         busy <= (state_reg != ST_IDLE) ? !last_beat : req.start;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         address_strobe_n <= ccb_pkg::PIN_IDLE;
      end else begin
         address_strobe_n <= !((state_reg == ST_IDLE) && req.start);
      end
   end

   // ****************************************************************
   // Linefill intent and final transfer
   // ****************************************************************
   // Intent is only asserted for reads; writes hold it high in both modes.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         linefill_intent_n <= ccb_pkg::PIN_IDLE;
      end else if (state_reg == ST_IDLE) begin
         linefill_intent_n <= !(req.start && req.want_fill && !req.write);
      end else if (last_beat) begin
         linefill_intent_n <= ccb_pkg::PIN_IDLE;
      end
   end

   // Only the single-transfer case with the grant refused ends on the first beat;
   // intent alone never drives this high.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         final_transfer_n <= ccb_pkg::PIN_IDLE;
         granted          <= 1'b0;
      end else if (state_reg == ST_ADDR || (state_reg == ST_DATA && !last_beat)) begin
         granted          <= fill_reg && !grant_n_s;
         final_transfer_n <= !((left_reg == ccb_pkg::XFER_ONE) && grant_n_s);
      end else begin
         final_transfer_n <= ccb_pkg::PIN_IDLE;
      end
   end

   // ****************************************************************
   // Snoop results
   // ****************************************************************
   // A dirty hit keeps the output low until the core reports that the writeback is done.
   // The report comes after the last beat of the writeback. The output is released on
   // the edge that takes the report, the same edge that can take a new start, so the
   // pin is high by the cycle in which the next strobe can first appear.
   // A new hit in the same cycle as the report wins, and the output stays low.
   logic dirty_pend_reg;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         dirty_pend_reg <= 1'b0;
      end else if (!copyback_mode) begin
         dirty_pend_reg <= 1'b0;
      end else if (snoop.hit_dirty) begin
         dirty_pend_reg <= 1'b1;
      end else if (snoop.wb_done) begin
         dirty_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         snoop_clean_match_n <= ccb_pkg::PIN_IDLE;
         snoop_dirty_match_n <= ccb_pkg::PIN_IDLE;
      end else if (!copyback_mode) begin
         snoop_clean_match_n <= ccb_pkg::PIN_IDLE;
         snoop_dirty_match_n <= ccb_pkg::PIN_IDLE;
      end else begin
         snoop_clean_match_n <= !snoop.hit_clean;
         snoop_dirty_match_n <= !(snoop.hit_dirty
                                  || (dirty_pend_reg && !snoop.wb_done));
      end
   end

endmodule

/* tb/ccb_chipset.sv */
// Chipset model facing the cache-control pins.
// Assumes the tb picks the grant level and pace between cycles.
`timescale 1ns/1ps
module ccb_chipset (
   // Clock and pins
   input  wire logic core_clk,
   input  wire logic address_strobe_n,
   output logic      cacheability_grant_n,
   output logic      burst_done_n,
   // Test controls
   input  wire logic grant_ok,
   input  wire logic slow
);
   int cnt = 0;
   // Ready is held for a span of clocks so it survives the pin synchroniser.
   always @(posedge core_clk) begin
      if (!address_strobe_n) cnt <= slow ? 12 : 8;
      else if (cnt > 0) cnt <= cnt - 1;
   end
   assign burst_done_n = !(cnt > 0 && cnt <= 6);
   assign cacheability_grant_n = !grant_ok;
endmodule

/* tb/ccb_pins_asserts.sv */
// Checker for the cache-control pins.
// Assumes one clock and the active-low reset of the design.
`timescale 1ns/1ps
module ccb_chk (
   // Clock and reset
   input wire logic                core_clk,
   input wire logic                resetn,
   // Core side
   input wire ccb_pkg::ccb_req_t   req,
   input wire ccb_pkg::ccb_snoop_t snoop,
   input wire logic                busy,
   input wire logic                copyback_mode,
   // Bus pins
   input wire logic                address_strobe_n,
   input wire logic                linefill_intent_n,
   input wire logic                final_transfer_n,
   input wire logic                snoop_clean_match_n,
   input wire logic                snoop_dirty_match_n
);
   // ****************
   // Assertions
   // ****************
   logic wr_reg;
   logic wb_reg;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   sequence s_take; req.start && !busy; endsequence
   sequence s_fill; s_take ##0 !req.write && req.want_fill; endsequence
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) wr_reg <= 1'b0;
      else if (req.start && !busy) wr_reg <= req.write;
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) wb_reg <= 1'b0;
      else if (snoop.hit_dirty) wb_reg <= 1'b0;
      else if (snoop.wb_done) wb_reg <= 1'b1;
   end
   chk_strobe_take: assert property (s_take |=> $fell(address_strobe_n))
      else $error("strobe missing after start");
   chk_strobe_width: assert property ($fell(address_strobe_n) |=> address_strobe_n)
      else $error("strobe longer than one cycle");
   chk_fill_intent: assert property (s_fill |=> !linefill_intent_n)
      else $error("intent not low on fill read");
   chk_write_intent: assert property (busy && wr_reg |-> linefill_intent_n)
      else $error("intent low during write");
   chk_wt_snoop: assert property (!copyback_mode |-> snoop_clean_match_n && snoop_dirty_match_n)
      else $error("snoop output low in write-through");
   chk_dirty_hit: assert property (copyback_mode && snoop.hit_dirty |=> !snoop_dirty_match_n)
      else $error("dirty match not low after hit");
   chk_dirty_hold: assert property (!snoop_dirty_match_n && !wb_reg && !snoop.wb_done |=> !snoop_dirty_match_n)
      else $error("dirty match released early");
   chk_dirty_free: assert property (!address_strobe_n && wb_reg |-> snoop_dirty_match_n)
      else $error("dirty match low at strobe");
   chk_final_phase: assert property ($fell(final_transfer_n) |-> busy && address_strobe_n)
      else $error("final transfer outside data phase");
endmodule
bind ccb_pins ccb_chk u_chk (.core_clk(core_clk), .resetn(resetn), .req(req), .snoop(snoop),
   .busy(busy), .copyback_mode(copyback_mode), .address_strobe_n(address_strobe_n),
   .linefill_intent_n(linefill_intent_n), .final_transfer_n(final_transfer_n),
   .snoop_clean_match_n(snoop_clean_match_n), .snoop_dirty_match_n(snoop_dirty_match_n));

/* tb/tb_top.sv */
// Testbench for the cache-control pins with a chipset model.
// Assumes inputs change on falling edges only.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
   $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb_top;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic cb_sel = 1'b1;
   logic grant_ok = 1'b0;
   logic slow = 1'b0;
   ccb_pkg::ccb_req_t req = '0;
   ccb_pkg::ccb_snoop_t snoop = '0;
   logic busy, mode, gnt, grant_n, done_n, strobe_n, intent_n, final_n, clean_n, dirty_n;
   int errors = 0, checks_done = 0, seed = 9732, n_stb = 0, n_int = 0, n_fin = 0;
   always #25 core_clk = ~core_clk;
   ccb_pins DUT (.core_clk(core_clk), .resetn(resetn), .copyback_select(cb_sel), .req(req),
      .snoop(snoop), .busy(busy), .copyback_mode(mode), .granted(gnt),
      .cacheability_grant_n(grant_n), .burst_done_n(done_n), .address_strobe_n(strobe_n),
      .linefill_intent_n(intent_n), .final_transfer_n(final_n),
      .snoop_clean_match_n(clean_n), .snoop_dirty_match_n(dirty_n));
   ccb_chipset u_cs (.core_clk(core_clk), .address_strobe_n(strobe_n),
      .cacheability_grant_n(grant_n), .burst_done_n(done_n), .grant_ok(grant_ok), .slow(slow));
   always @(posedge core_clk) begin
      n_stb += !strobe_n;
      n_int += !intent_n;
      n_fin += !final_n;
   end
   // ****************
   // Tasks
   // ****************
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic do_reset(input logic cb);
      resetn = 1'b0;
      cb_sel = cb;
      repeat (16) @(negedge core_clk);
      resetn = 1'b1;
      repeat (4) @(negedge core_clk);
      `CHK("mode", cb, mode)
      `CHK("pins", 5'h1f, {strobe_n, intent_n, final_n, clean_n, dirty_n})
   endtask
   task automatic pulse(input ccb_pkg::ccb_snoop_t v);
      snoop = v;
      @(negedge core_clk);
      snoop = '0;
   endtask
   // A second start while busy must be ignored, so only one strobe is counted.
   task automatic op(input logic w, f, input logic [1:0] x, input logic g, s, rf);
      int k;
      grant_ok = g;
      slow = s;
      repeat (6) @(negedge core_clk);
      n_stb = 0; n_int = 0; n_fin = 0;
      req = '{1'b1, w, f, x};
      @(negedge core_clk);
      req.start = 1'b0;
      @(negedge core_clk);
      req.start = rf;
      @(negedge core_clk);
      req.start = 1'b0;
      for (k = 0; k < 60 && busy !== 1'b0; k++) @(negedge core_clk);
      `CHK("busy", 1'b0, busy)
      repeat (3) @(negedge core_clk);
      `CHK("strobes", 1, n_stb)
      `CHK("intent", !w && f, n_int > 0)
      if (!w) `CHK("final", x <= 2'h1 && !g, n_fin > 0)
      `CHK("granted", !w && f && g, gnt)
   endtask
   initial begin
      logic [31:0] r;
      do_reset(1'b1);
      pulse(3'h2);
      `CHK("dirty hit", 1'b0, dirty_n)
      pulse(3'h4);
      `CHK("clean hit", 1'b0, clean_n)
      op(1'b0, 1'b1, 2'h1, 1'b0, 1'b1, 1'b1);
      `CHK("dirty held", 1'b0, dirty_n)
      pulse(3'h1);
      op(1'b0, 1'b1, 2'h3, 1'b1, 1'b0, 1'b0);
      `CHK("dirty free", 1'b1, dirty_n)
      for (int m = 0; m < 2; m++) begin
         if (m == 1) begin
            do_reset(1'b0);
            pulse(3'h6);
            `CHK("snoop wt", 2'h3, {clean_n, dirty_n})
         end
         repeat (12) begin
            r = $random(seed);
            op(r[0], r[1], r[3:2], r[4], r[5], r[6]);
         end
      end
      wrap_up();
   end
   initial begin
      #(50 * 6000);
      errors++;
      wrap_up();
   end
endmodule
